// file: rtl/reply_watch_map.vh
`ifndef REPLY_WATCH_MAP_VH
`define REPLY_WATCH_MAP_VH

// register offsets
`define RW_ADDR_DELAY_B     8'h15
`define RW_ADDR_TRIG_A      8'h16
`define RW_ADDR_TRIG_B      8'h17
`define RW_ADDR_TRIGGER     8'h1f

// reply delay config fields
`define RW_DLY_FLAG_BIT     7
`define RW_DLY_GAP_HI       6
`define RW_DLY_GAP_LO       5
`define RW_DLY_WAIT_HI      4
`define RW_DLY_WAIT_LO      1
`define RW_DLY_ON_BIT       0

// trigger assignment fields
`define RW_TRIG_CODE_HI     7
`define RW_TRIG_CODE_LO     4
`define RW_TRIG_EN_BIT      0

// trigger register value field
`define RW_TRIGVAL_HI       7
`define RW_TRIGVAL_LO       4
`define RW_TRIG_GLOBAL      4'h0

// reset values
`define RW_DELAY_B_RST      8'h00
`define RW_TRIG_RST         8'h00
`define RW_RDATA_UNMAPPED   8'h00

// timing, in bit intervals
`define RW_BASE_REPLY_BITS  5'h0a
`define RW_BASE_GAP_BITS    5'h03

// line clock and baud rates in hertz
`define RW_CLK_HZ           125000000
`define RW_BAUD_COM1        4800
`define RW_BAUD_COM2        38400
`define RW_BAUD_COM3        230400

// baud select codes
`define RW_BAUD_SEL_COM1    2'h0
`define RW_BAUD_SEL_COM2    2'h1
`define RW_BAUD_SEL_COM3    2'h2

`endif

// file: rtl/reply_watchdog_and_tx_trigger.v
`timescale 1ns/1ps
`include "reply_watch_map.vh"

// Functional notes
// R1 - set channel b late-reply flag when the reply misses its allowed delay
// R2 - a newly set late-reply flag pulses the receive-error interrupt
// R3 - reading the delay config register clears the late-reply flag only
// R4 - two-bit field adds 0 to 3 bit intervals to the byte gap
// R5 - four-bit field adds 0 to 15 bits to the 10-bit reply wait
// R6 - host should program the extra reply wait with one
// R7 - with watch enabled, reply timing starts at the master's last stop bit
// R8 - late first reply and oversize byte gap both flag and interrupt
// R9 - with watch disabled, no monitoring and the flag reads zero
// R10 - each channel holds a 4-bit launch code in bits 7 to 4
// R11 - trigger write matching the launch code sends the transmit queue at once
// R12 - a matching trigger also starts the cycle timer when it is enabled
// R13 - trigger value zero launches every channel whose enable bit 0 is set, the same as a matching launch code
// R14 - bit 0 enables triggering; when clear the launch code is ignored
// R15 - trigger assignment bits 3 to 1 read zero and ignore writes
// R16 - channel b trigger register works the same on its own queue
// R17 - reply bit interval follows the configured line baud rate
module reply_watchdog_and_tx_trigger #(
	parameter CLK_HZ   = `RW_CLK_HZ,
	parameter DIV_COM1 = `RW_CLK_HZ / `RW_BAUD_COM1,
	parameter DIV_COM2 = `RW_CLK_HZ / `RW_BAUD_COM2,
	parameter DIV_COM3 = `RW_CLK_HZ / `RW_BAUD_COM3
) (
	// clock and reset
	input  wire       clk_sys_i,
	input  wire       reset_n_i,
	// register port behind the serial host interface
	input  wire [7:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	output wire [7:0] reg_rdata_o,
	// channel b line events
	input  wire [1:0] baud_sel_b_i,
	input  wire       tx_last_stop_b_i,
	input  wire       rx_start_b_i,
	input  wire       rx_byte_done_b_i,
	input  wire       rx_msg_done_b_i,
	output wire       late_reply_flag_b_o,
	output wire       rx_fault_irq_b_o,
	// transmit launch, both channels
	input  wire       cycle_timer_on_a_i,
	input  wire       cycle_timer_on_b_i,
	output wire       tx_queue_send_a_o,
	output wire       tx_queue_send_b_o,
	output wire       cycle_start_a_o,
	output wire       cycle_start_b_o
);

	localparam [3:0] S_IDLE  = 4'b0001;
	localparam [3:0] S_REPLY = 4'b0010;
	localparam [3:0] S_BYTE  = 4'b0100;
	localparam [3:0] S_GAP   = 4'b1000;

	// register access decode
	wire       wr_dly  = reg_wr_i && (reg_addr_i == `RW_ADDR_DELAY_B);
	wire       rd_dly  = reg_rd_i && (reg_addr_i == `RW_ADDR_DELAY_B);
	wire       wr_trig = reg_wr_i && (reg_addr_i == `RW_ADDR_TRIGGER);
	wire [3:0] trig_val = reg_wdata_i[`RW_TRIGVAL_HI:`RW_TRIGVAL_LO];

	// delay config fields of channel b
	reg  [1:0] extra_byte_gap_b_q;
	reg  [3:0] extra_reply_wait_b_q;
	reg        reply_watch_on_b_q;
	reg        late_reply_flag_b_q;
	reg        rx_fault_irq_b_q;

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			extra_byte_gap_b_q   <= 2'h0;
			extra_reply_wait_b_q <= 4'h0;
			reply_watch_on_b_q   <= 1'b0;
		end else if (wr_dly) begin
			// flag bit is read only, write ignored there
			extra_byte_gap_b_q   <= reg_wdata_i[`RW_DLY_GAP_HI:`RW_DLY_GAP_LO]; // R4
			extra_reply_wait_b_q <= reg_wdata_i[`RW_DLY_WAIT_HI:`RW_DLY_WAIT_LO]; // R5
			reply_watch_on_b_q   <= reg_wdata_i[`RW_DLY_ON_BIT];
		end
	end

	// dividers cut to the counter width on purpose; the slowest rate still fits
	localparam [15:0] DIV1_W = DIV_COM1[15:0];
	localparam [15:0] DIV2_W = DIV_COM2[15:0];
	localparam [15:0] DIV3_W = DIV_COM3[15:0];

	// base allowances in bit intervals
	localparam [4:0] BASE_REPLY = `RW_BASE_REPLY_BITS;
	localparam [4:0] BASE_GAP   = `RW_BASE_GAP_BITS;

	// bit interval from the selected baud rate
	reg [15:0] bit_div;

	always @* begin
		bit_div = DIV3_W;
		case (baud_sel_b_i)
			`RW_BAUD_SEL_COM1: bit_div = DIV1_W; // R17
			`RW_BAUD_SEL_COM2: bit_div = DIV2_W; // R17
			`RW_BAUD_SEL_COM3: bit_div = DIV3_W; // R17
			default: begin
				// spare code runs at the fastest rate
				bit_div = DIV3_W;
			end
		endcase
	end

	// reply watchdog state
	reg  [3:0]  state_q;
	reg  [3:0]  state_d;
	reg  [15:0] div_q;
	reg  [4:0]  bit_cnt_q;
	reg         restart;
	reg         timeout_set;

	wire       bit_tick  = (div_q == bit_div - 16'h0001);
	wire [4:0] wait_ext  = {1'b0, extra_reply_wait_b_q};
	wire [4:0] gap_ext   = {3'h0, extra_byte_gap_b_q};
	wire [4:0] reply_lim = BASE_REPLY + wait_ext; // R5
	wire [4:0] gap_lim   = BASE_GAP + gap_ext; // R4
	wire [4:0] bit_next  = bit_cnt_q + 5'h01;
	reg  [4:0] cur_lim;
	wire       expired   = bit_tick && (bit_next == cur_lim);

	// the byte gap has its own, shorter allowance
	always @* begin
		case (state_q)
			S_GAP:   cur_lim = gap_lim; // R4
			S_REPLY: cur_lim = reply_lim; // R5
			default: cur_lim = reply_lim;
		endcase
	end

	always @* begin
		state_d     = state_q;
		restart     = 1'b0;
		timeout_set = 1'b0;
		if (!reply_watch_on_b_q) begin
			state_d = S_IDLE; // R9
		end else if (tx_last_stop_b_i) begin
			// a new master message always restarts the wait
			state_d = S_REPLY; // R7
			restart = 1'b1;
		end else begin
			case (state_q)
				S_IDLE: begin
					state_d = S_IDLE;
				end
				S_REPLY: begin
					if (rx_start_b_i) begin
						state_d = S_BYTE;
					end else if (expired) begin
						state_d     = S_IDLE;
						timeout_set = 1'b1; // R1
					end
				end
				S_BYTE: begin
					if (rx_msg_done_b_i) begin
						state_d = S_IDLE;
					end else if (rx_byte_done_b_i) begin
						state_d = S_GAP;
						restart = 1'b1;
					end
				end
				S_GAP: begin
					if (rx_msg_done_b_i) begin
						state_d = S_IDLE;
					end else if (rx_start_b_i) begin
						state_d = S_BYTE;
					end else if (expired) begin
						state_d     = S_IDLE;
						timeout_set = 1'b1; // R8
					end
				end
				default: begin
					state_d = S_IDLE;
				end
			endcase
		end
	end

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// counter parked while idle or inside a byte, so each wait starts from zero
	wire count_hold = restart || (state_q == S_IDLE) || (state_q == S_BYTE);

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_q <= 16'h0000;
		end else if (count_hold || bit_tick) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bit_cnt_q <= 5'h00;
		end else if (count_hold) begin
			bit_cnt_q <= 5'h00;
		end else if (bit_tick) begin
			bit_cnt_q <= bit_next;
		end
	end

	// set wins over the clear on read
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			late_reply_flag_b_q <= 1'b0;
			rx_fault_irq_b_q    <= 1'b0;
		end else begin
			rx_fault_irq_b_q <= timeout_set; // R2
			if (!reply_watch_on_b_q) begin
				late_reply_flag_b_q <= 1'b0; // R9
			end else if (wr_dly && !reg_wdata_i[`RW_DLY_ON_BIT]) begin
				// switching the watch off drops the flag in the same edge
				late_reply_flag_b_q <= 1'b0; // R9
			end else if (timeout_set) begin
				late_reply_flag_b_q <= 1'b1; // R1
			end else if (rd_dly) begin
				late_reply_flag_b_q <= 1'b0; // R3
			end
		end
	end

	// trigger assignment, one per channel
	wire [1:0] cyc_on = {cycle_timer_on_b_i, cycle_timer_on_a_i};
	wire [1:0] send;
	wire [1:0] cyc_start;
	wire [7:0] assign_rd [0:1];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			localparam [7:0] ASSIGN_OFS = ch;
			reg  [3:0] launch_code_q;
			reg        launch_match_on_q;
			reg        send_q;
			reg        cyc_q;
			wire       wr_assign  = reg_wr_i && (reg_addr_i == `RW_ADDR_TRIG_A + ASSIGN_OFS); // R16
			wire       code_match = (trig_val == launch_code_q); // R11
			wire       all_match  = (trig_val == `RW_TRIG_GLOBAL); // R13
			// a disabled channel ignores its code and the global value too
			wire       hit        = launch_match_on_q && (code_match || all_match); // R14

			always @(posedge clk_sys_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					launch_code_q     <= 4'h0;
					launch_match_on_q <= 1'b0;
				end else if (wr_assign) begin
					launch_code_q     <= reg_wdata_i[`RW_TRIG_CODE_HI:`RW_TRIG_CODE_LO]; // R10
					launch_match_on_q <= reg_wdata_i[`RW_TRIG_EN_BIT]; // R14
				end
			end

			// launch pulses are registered so the queue sees one clean cycle
			always @(posedge clk_sys_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					send_q <= 1'b0;
					cyc_q  <= 1'b0;
				end else begin
					send_q <= wr_trig && hit; // R11
					cyc_q  <= wr_trig && hit && cyc_on[ch]; // R12
				end
			end

			assign send[ch]      = send_q;
			assign cyc_start[ch] = cyc_q;
			assign assign_rd[ch] = {launch_code_q, 3'h0, launch_match_on_q}; // R15
		end
	endgenerate

	assign tx_queue_send_a_o = send[0];
	assign tx_queue_send_b_o = send[1];
	assign cycle_start_a_o   = cyc_start[0];
	assign cycle_start_b_o   = cyc_start[1];

	// read view of the delay register, flag shown as stored
	reg [7:0] dly_rd_word;

	always @* begin
		dly_rd_word = 8'h00;
		dly_rd_word[`RW_DLY_FLAG_BIT]                = late_reply_flag_b_q; // R3
		dly_rd_word[`RW_DLY_GAP_HI:`RW_DLY_GAP_LO]   = extra_byte_gap_b_q;
		dly_rd_word[`RW_DLY_WAIT_HI:`RW_DLY_WAIT_LO] = extra_reply_wait_b_q;
		dly_rd_word[`RW_DLY_ON_BIT]                  = reply_watch_on_b_q;
	end

	// read data, captured on the read strobe
	reg [7:0] rdata_q;

	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_q <= `RW_RDATA_UNMAPPED;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`RW_ADDR_DELAY_B: rdata_q <= dly_rd_word;
				`RW_ADDR_TRIG_A:  rdata_q <= assign_rd[0];
				// trigger register is write only, reads as empty
				`RW_ADDR_TRIGGER: rdata_q <= `RW_RDATA_UNMAPPED;
				`RW_ADDR_TRIG_B:  rdata_q <= assign_rd[1];
				default:          rdata_q <= `RW_RDATA_UNMAPPED;
			endcase
		end
	end

	assign reg_rdata_o         = rdata_q;
	assign late_reply_flag_b_o = late_reply_flag_b_q;
	assign rx_fault_irq_b_o    = rx_fault_irq_b_q;

endmodule // reply_watchdog_and_tx_trigger

// file: tb/remote_dev.sv
`timescale 1ns/1ps
module remote_dev (
	// clock and master message end
	input  wire       clk_sys_i,
	input  wire       tx_last_stop_b_i,
	// reply shape in cycles; zero reply stays silent
	input  wire [7:0] reply_i,
	input  wire [7:0] gap_i,
	// line events
	output reg        rx_start_o,
	output reg        byte_done_o,
	output reg        msg_done_o
);
	integer n;
	initial begin
		{rx_start_o, byte_done_o, msg_done_o} = 3'h0;
		forever begin
			@(posedge clk_sys_i);
			if (tx_last_stop_b_i === 1'b1 && reply_i != 8'h00) begin
				repeat (reply_i) @(posedge clk_sys_i);
				for (n = 0; n < 2; n = n + 1) begin
					if (n != 0) repeat (gap_i) @(posedge clk_sys_i);
					#1 rx_start_o = 1'b1;
					@(posedge clk_sys_i) #1 rx_start_o = 1'b0;
					repeat (3) @(posedge clk_sys_i);
					#1 byte_done_o = 1'b1;
					@(posedge clk_sys_i) #1 byte_done_o = 1'b0;
				end
				msg_done_o = 1'b1;
				@(posedge clk_sys_i) #1 msg_done_o = 1'b0;
			end
		end
	end
endmodule // remote_dev

// file: tb/rw_chk_asserts.sv
`timescale 1ns/1ps
module rw_chk (
	// watched ports
	input wire       clk_sys_i,
	input wire       reset_n_i,
	input wire [7:0] reg_addr_i,
	input wire       reg_wr_i,
	input wire       reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire       late_reply_flag_b_o,
	input wire       rx_fault_irq_b_o,
	input wire       cycle_timer_on_a_i,
	input wire       cycle_timer_on_b_i,
	input wire       tx_queue_send_a_o,
	input wire       tx_queue_send_b_o,
	input wire       cycle_start_a_o,
	input wire       cycle_start_b_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	wire trig_wr = reg_wr_i && reg_addr_i == 8'h1f;
	wire dly_rd  = reg_rd_i && reg_addr_i == 8'h15;
	wire dly_wr  = reg_wr_i && reg_addr_i == 8'h15;
	sequence s_irq_pulse;
		rx_fault_irq_b_o ##1 !rx_fault_irq_b_o;
	endsequence
	flag_rise_irq_a: assert property ($rose(late_reply_flag_b_o) |-> s_irq_pulse)
		else $error("flag rose without one irq pulse");
	irq_flag_a: assert property (rx_fault_irq_b_o |-> late_reply_flag_b_o)
		else $error("irq without flag");
	read_clear_a: assert property (dly_rd |=> !late_reply_flag_b_o || rx_fault_irq_b_o)
		else $error("flag not cleared by read");
	flag_holds_a: assert property (late_reply_flag_b_o && !dly_rd && !dly_wr |=> late_reply_flag_b_o)
		else $error("flag dropped on its own");
	unused_bits_a: assert property (reg_rd_i && reg_addr_i[7:1] == 7'h0b |=> reg_rdata_o[3:1] == 3'h0)
		else $error("unused trigger bits not zero");
	send_cause_a: assert property (tx_queue_send_a_o || tx_queue_send_b_o |-> $past(trig_wr))
		else $error("send without trigger write");
	cyc_start_a_a: assert property (cycle_start_a_o |-> tx_queue_send_a_o && $past(cycle_timer_on_a_i))
		else $error("bad cycle start a");
	cyc_start_b_a: assert property (cycle_start_b_o |-> tx_queue_send_b_o && $past(cycle_timer_on_b_i))
		else $error("bad cycle start b");
endmodule // rw_chk

bind reply_watchdog_and_tx_trigger rw_chk u_rw_chk (.*);

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	reg         clk_sys_i = 1'b0;
	reg         reset_n_i = 1'b0;
	reg  [7:0]  reg_addr_i = 8'h00;
	reg  [7:0]  reg_wdata_i = 8'h00;
	reg         reg_wr_i = 1'b0;
	reg         reg_rd_i = 1'b0;
	reg  [1:0]  baud_sel_b_i = 2'h2;
	reg         tx_stop = 1'b0;
	reg  [1:0]  ton = 2'h0;
	reg  [7:0]  reply = 8'h00;
	reg  [7:0]  gap = 8'h00;
	reg  [7:0]  cfg;
	reg         e;
	wire [7:0]  reg_rdata_o;
	wire        rs, bd, md, flag, irq, sa, sb, ca, cb;
	integer     miscompares = 0;
	integer     samples_checked = 0;
	integer     i, j, n, k;
	// cfg, reply, gap, expected flag
	localparam [174:0] TBL = {8'h03, 8'h00, 8'h00, 1'b1, 8'h03, 8'h0f, 8'h02, 1'b0, 8'h03, 8'h1e, 8'h02, 1'b1,
		8'h1f, 8'h28, 8'h02, 1'b0, 8'h03, 8'h0a, 8'h08, 1'b1, 8'h63, 8'h0a, 8'h08, 1'b0, 8'h02, 8'h00, 8'h00, 1'b0};
	reply_watchdog_and_tx_trigger #(.DIV_COM1(8), .DIV_COM2(4), .DIV_COM3(2)) dut (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .baud_sel_b_i(baud_sel_b_i),
		.tx_last_stop_b_i(tx_stop), .rx_start_b_i(rs), .rx_byte_done_b_i(bd), .rx_msg_done_b_i(md),
		.late_reply_flag_b_o(flag), .rx_fault_irq_b_o(irq), .cycle_timer_on_a_i(ton[1]),
		.cycle_timer_on_b_i(ton[0]), .tx_queue_send_a_o(sa), .tx_queue_send_b_o(sb), .cycle_start_a_o(ca),
		.cycle_start_b_o(cb));
	remote_dev u_dev (.clk_sys_i(clk_sys_i), .tx_last_stop_b_i(tx_stop), .reply_i(reply), .gap_i(gap),
		.rx_start_o(rs), .byte_done_o(bd), .msg_done_o(md));
	initial forever #4 clk_sys_i = ~clk_sys_i;
	task cmp(input [7:0] got, input [7:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cmp_bit(input got, input exp);
		cmp({7'h00, got}, {7'h00, exp});
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk_sys_i) #1;
		{reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
		@(posedge clk_sys_i) #1 reg_wr_i = 1'b0;
	endtask
	task rd(input [7:0] a, input [7:0] exp);
		@(posedge clk_sys_i) #1;
		{reg_addr_i, reg_rd_i} = {a, 1'b1};
		@(posedge clk_sys_i) #1 reg_rd_i = 1'b0;
		cmp(reg_rdata_o, exp);
	endtask
	task stop_pulse;
		@(posedge clk_sys_i) #1 tx_stop = 1'b1;
		@(posedge clk_sys_i) #1 tx_stop = 1'b0;
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// whole run is near 1100 cycles
	initial begin
		#100000;
		miscompares = miscompares + 1;
		complete_run;
	end
	initial begin
		repeat (20) @(posedge clk_sys_i);
		#1 reset_n_i = 1'b1;
		rd(8'h15, 8'h00);
		rd(8'h16, 8'h00);
		rd(8'h17, 8'h00);
		rd(8'h30, 8'h00);
		for (j = 0; j < 4; j = j + 1) begin
			baud_sel_b_i = j[1:0];
			k = (j == 3) ? 2 : j;
			wr(8'h15, 8'h03);
			stop_pulse;
			n = 0;
			while (!flag && n < 200) begin
				@(posedge clk_sys_i) #1 n = n + 1;
			end
			cmp_bit(n == (11 << (3 - k)) || n == (11 << (3 - k)) + 1, 1'b1);
			cmp_bit(irq, 1'b1);
			wr(8'h15, 8'h02);
			cmp_bit(flag, 1'b0);
		end
		baud_sel_b_i = 2'h2;
		for (i = 0; i < 7; i = i + 1) begin
			{cfg, reply, gap, e} = TBL[i * 25 +: 25];
			wr(8'h15, cfg);
			stop_pulse;
			repeat (100) @(posedge clk_sys_i);
			#1 cmp_bit(flag, e);
			rd(8'h15, {e, cfg[6:0]});
			rd(8'h15, {1'b0, cfg[6:0]});
		end
		wr(8'h16, 8'h5f);
		rd(8'h16, 8'h51);
		wr(8'h17, 8'h71);
		rd(8'h17, 8'h71);
		rd(8'h1f, 8'h00);
		for (j = 0; j < 2; j = j + 1)
			for (i = 0; i < 16; i = i + 1) begin
				ton = (j == 0) ? 2'h2 : 2'h1;
				wr(8'h1f, {i[3:0], 4'h0});
				cmp_bit(sa, i == 5 || i == 0);
				cmp_bit(sb, i == 7 || i == 0);
				cmp_bit(ca, (i == 5 || i == 0) && ton[1]);
				cmp_bit(cb, (i == 7 || i == 0) && ton[0]);
			end
		wr(8'h16, 8'h50);
		wr(8'h1f, 8'h50);
		cmp_bit(sa, 1'b0);
		wr(8'h1f, 8'h00);
		cmp_bit(sa, 1'b0);
		cmp_bit(sb, 1'b1);
		complete_run;
	end
endmodule // testbench
